// ===== dv/pem_cpu_model.sv
// Processor-side partner: acknowledges postings, keeps what was posted
`timescale 1ns/100ps
module pem_cpu_model (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [3:0]  ack_delay_in,
  input  wire logic        store_req_in,
  input  wire logic [23:0] store_waddr_in,
  input  wire logic [31:0] store_wdata_in,
  input  wire logic        int_req_in,
  input  wire logic [23:0] old_addr_in,
  output logic             post_ack_out,
  output logic [31:0]      code_word_out,
  output logic [31:0]      addr_word_out,
  output logic [23:0]      old_addr_out,
  output logic [7:0]       ack_count_out
);
  logic [3:0] wait_cnt;
  logic       pend;
  assign pend = (store_req_in || int_req_in) && !post_ack_out;
  // Settable wait so slow answers are exercised too
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_cnt <= 4'h0;
      post_ack_out <= 1'b0;
    end else begin
      post_ack_out <= pend && wait_cnt == ack_delay_in;
      wait_cnt <= (pend && wait_cnt != ack_delay_in) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {code_word_out, addr_word_out, old_addr_out, ack_count_out} <= '0;
    end else if (post_ack_out) begin
      ack_count_out <= ack_count_out + 8'h01;
      if (store_req_in && store_waddr_in == 24'h000094) code_word_out <= store_wdata_in;
      if (store_req_in && store_waddr_in == 24'h000098) addr_word_out <= store_wdata_in;
      if (int_req_in) old_addr_out <= old_addr_in;
    end
  end
endmodule

// ===== dv/pem_monitor_sva.sv
// Port checks for the program event monitor
`timescale 1ns/100ps
module pem_monitor_sva #(
  parameter int ADDR_W = 24
) (
  input wire logic              core_clk_in,
  input wire logic              rst_n_in,
  input wire logic              extended_control_mode_in,
  input wire logic              event_mask_in,
  input wire logic              instr_done_in,
  input wire logic              post_ack_in,
  input wire logic              int_req_out,
  input wire logic [7:0]        int_code_out,
  input wire logic              store_req_out,
  input wire logic [ADDR_W-1:0] store_waddr_out,
  input wire logic [31:0]       store_wdata_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic idle;
  logic w94;
  assign idle = !store_req_out && !int_req_out;
  assign w94 = store_req_out && store_waddr_out == 24'h000094;
  chk_int_code:
    assert property (int_req_out |-> int_code_out == 8'h80) else $error("bad code");
  chk_code_word:
    assert property ($rose(store_req_out) |-> w94 && store_wdata_out[31:16] == 16'h0
      && store_wdata_out[7:0] == 8'h00) else $error("bad first posting");
  chk_spare_bits:
    assert property (w94 |-> store_wdata_out[11:8] == 4'h0 && store_wdata_out[15:12] != 4'h0)
      else $error("bad code bits");
  chk_addr_word:
    assert property (w94 && post_ack_in |=> store_req_out && store_waddr_out == 24'h000098
      && store_wdata_out[31:24] == 8'h00) else $error("bad second posting");
  chk_int_follow:
    assert property (store_req_out && !w94 && post_ack_in |=> int_req_out && !store_req_out)
      else $error("no interruption");
  chk_req_hold:
    assert property (store_req_out && !post_ack_in |=> store_req_out && $stable(store_wdata_out))
      else $error("posting dropped");
  chk_masked_drop:
    assert property (instr_done_in && idle && !event_mask_in |=> idle) else $error("not masked");
  chk_mode_gate:
    assert property (instr_done_in && idle && !extended_control_mode_in |=> idle)
      else $error("not gated");
  chk_int_release:
    assert property (int_req_out && post_ack_in |=> idle) else $error("stuck request");
endmodule
bind pem_monitor pem_monitor_sva #(.ADDR_W(ADDR_W)) pem_monitor_sva_i (.*);

// ===== dv/tb_pem_monitor.sv
// Self-checking bench for the program event monitor
`timescale 1ns/100ps
module tb_pem_monitor import pem_pkg::*;;
  logic core_clk_in, rst_n_in, avs_read_in, avs_write_in, post_ack_in, instr_done_in;
  logic extended_control_mode_in, event_mask_in, exec_valid_in, is_branch_in;
  logic branch_taken_in, is_load_status_in, store_valid_in, store_cpu_own_in;
  logic avs_waitrequest_out, int_req_out, store_req_out;
  logic [3:0] avs_address_in, avs_byteenable_in, ack_delay;
  logic [31:0] avs_writedata_in, avs_readdata_out, store_wdata_out, code_word, addr_word, rd;
  logic [23:0] instr_addr_in, next_addr_in, exec_addr_in, branch_target_in, store_addr_in;
  logic [23:0] store_waddr_out, old_status_addr_out, old_addr;
  logic [15:0] gr_write_in;
  logic [7:0] int_code_out, acks;
  int err_total, total_checks;
  pem_monitor pem_monitor_i (.*);
  pem_cpu_model pem_cpu_model_i (.core_clk_in, .rst_n_in, .ack_delay_in(ack_delay),
    .store_req_in(store_req_out), .store_waddr_in(store_waddr_out),
    .store_wdata_in(store_wdata_out), .int_req_in(int_req_out),
    .old_addr_in(old_status_addr_out), .post_ack_out(post_ack_in),
    .code_word_out(code_word), .addr_word_out(addr_word), .old_addr_out(old_addr),
    .ack_count_out(acks));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    {avs_write_in, avs_read_in, avs_address_in, avs_writedata_in} <= {w, !w, a, d};
    // No cycle count assumed; the watchdog ends a hung wait
    do begin
      @(posedge core_clk_in);
    end while (avs_waitrequest_out);
    rd = avs_readdata_out;
    {avs_write_in, avs_read_in} <= 2'b00;
  endtask
  // Flags: exec, branch, taken, load status, store, own store
  task automatic ev(input logic [23:0] ia, ea, tgt, sa, input logic [15:0] gw,
                    input logic [5:0] f, input logic [7:0] code, input logic [23:0] eea, eold);
    logic [7:0] a0;
    a0 = acks;
    @(posedge core_clk_in);
    {exec_valid_in, is_branch_in, branch_taken_in, is_load_status_in, store_valid_in,
      store_cpu_own_in} <= f;
    {instr_addr_in, next_addr_in, exec_addr_in, branch_target_in, store_addr_in} <=
      {ia, ia + 24'h000004, ea, tgt, sa};
    gr_write_in <= gw;
    instr_done_in <= 1'b1;
    @(posedge core_clk_in);
    instr_done_in <= 1'b0;
    // Three acknowledges per event; none when nothing may be posted
    for (int i = 0; i < 60; i++) begin
      @(posedge core_clk_in);
      if (acks - a0 == 8'h03) break;
    end
    cmp({24'h0, acks - a0}, (code != 8'h00) ? 32'h3 : 32'h0);
    if (code != 8'h00) begin
      cmp(code_word, {16'h0, code, 8'h00});
      cmp(addr_word, {8'h00, eea});
      cmp({8'h00, old_addr}, {8'h00, eold});
      cmp({24'h0, int_code_out}, {24'h0, PEM_INT_CODE});
    end
  endtask
  task automatic t_regs;
    bus(0, PEM_ADDR_STATUS, 32'h0);
    cmp(rd, 32'h0000_0200);
    bus(1, PEM_ADDR_SELECT, 32'hF000_1000);
    bus(1, PEM_ADDR_START, 32'hAB00_1000);
    bus(1, PEM_ADDR_END, 32'h0000_1FFF);
    bus(1, 4'h2, 32'hFFFF_FFFF);
    bus(0, PEM_ADDR_SELECT, 32'h0);
    cmp(rd, 32'hF000_1000);
  endtask
  task automatic t_branch;
    ev(24'h000200, 24'h0, 24'h000300, 24'h0, 16'h0, 6'b011000, 8'h80, 24'h000200, 24'h000300);
    ev(24'h000200, 24'h000400, 24'h000300, 24'h0, 16'h0, 6'b111000, 8'h80, 24'h000400, 24'h000300);
    ev(24'h000200, 24'h0, 24'h000300, 24'h0, 16'h0, 6'b010000, 8'h00, 24'h0, 24'h0);
    ev(24'h000200, 24'h0, 24'h000300, 24'h0, 16'h0, 6'b011100, 8'h00, 24'h0, 24'h0);
  endtask
  task automatic t_access;
    ev(24'h001010, 24'h0, 24'h0, 24'h0, 16'h0, 6'b000000, 8'h40, 24'h001010, 24'h001014);
    ev(24'h000500, 24'h001FFF, 24'h0, 24'h0, 16'h0, 6'b100000, 8'h40, 24'h001FFF, 24'h000504);
    ev(24'h000200, 24'h0, 24'h0, 24'h001FFF, 16'h0, 6'b000010, 8'h20, 24'h000200, 24'h000204);
    ev(24'h000200, 24'h0, 24'h0, 24'h001FFF, 16'h0, 6'b000011, 8'h00, 24'h0, 24'h0);
    ev(24'h000200, 24'h0, 24'h0, 24'h000FFF, 16'h0, 6'b000010, 8'h00, 24'h0, 24'h0);
    ev(24'h000200, 24'h0, 24'h0, 24'h0, 16'h0018, 6'b000000, 8'h10, 24'h000200, 24'h000204);
    ev(24'h000200, 24'h0, 24'h0, 24'h0, 16'h0020, 6'b000000, 8'h00, 24'h0, 24'h0);
    ack_delay <= 4'h3;
    ev(24'h000200, 24'h0, 24'h000300, 24'h0, 16'h0008, 6'b011000, 8'h90, 24'h000200, 24'h000300);
    bus(0, PEM_ADDR_STATUS, 32'h0);
    cmp(rd, 32'h0000_0290);
  endtask
  task automatic t_wrap;
    bus(1, PEM_ADDR_START, 32'h00FF_F000);
    bus(1, PEM_ADDR_END, 32'h0000_0100);
    ev(24'h000200, 24'h0, 24'h0, 24'h000080, 16'h0, 6'b000010, 8'h20, 24'h000200, 24'h000204);
    ev(24'hFFF800, 24'h0, 24'h0, 24'h0, 16'h0, 6'b000000, 8'h40, 24'hFFF800, 24'hFFF804);
    event_mask_in <= 1'b0;
    ev(24'h000010, 24'h0, 24'h0, 24'h0, 16'h0, 6'b000000, 8'h00, 24'h0, 24'h0);
    {event_mask_in, extended_control_mode_in} <= 2'b10;
    ev(24'h000010, 24'h0, 24'h0, 24'h0, 16'h0, 6'b000000, 8'h00, 24'h0, 24'h0);
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  initial begin
    #200000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    {rst_n_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in, ack_delay} = '0;
    {instr_done_in, exec_valid_in, is_branch_in, branch_taken_in, is_load_status_in} = '0;
    {store_valid_in, store_cpu_own_in, gr_write_in, instr_addr_in, next_addr_in} = '0;
    {exec_addr_in, branch_target_in, store_addr_in} = '0;
    {extended_control_mode_in, event_mask_in, avs_byteenable_in} = 6'h3F;
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_branch;
    t_access;
    t_wrap;
    tally_and_finish;
  end
endmodule

// ===== rtl/pem_monitor.sv
// Program event monitor: event checks, storage posting and interruption request
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
module pem_monitor
  import pem_pkg::*;
#(
  parameter int ADDR_W = PEM_ADDR_W
) (
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  // Avalon-MM slave
  input  wire logic [3:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic [31:0]            avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // Processor status
  input  wire logic              extended_control_mode_in,
  input  wire logic              event_mask_in,
  // Instruction end report, one-cycle strobe with its data
  input  wire logic              instr_done_in,
  input  wire logic [ADDR_W-1:0] instr_addr_in,
  input  wire logic [ADDR_W-1:0] next_addr_in,
  input  wire logic              exec_valid_in,
  input  wire logic [ADDR_W-1:0] exec_addr_in,
  input  wire logic              is_branch_in,
  input  wire logic              branch_taken_in,
  input  wire logic [ADDR_W-1:0] branch_target_in,
  input  wire logic              is_load_status_in,
  input  wire logic              store_valid_in,
  input  wire logic [ADDR_W-1:0] store_addr_in,
  input  wire logic              store_cpu_own_in,
  input  wire logic [15:0]       gr_write_in,
  // Interruption request and posting
  input  wire logic              post_ack_in,
  output logic                   int_req_out,
  output logic [7:0]             int_code_out,
  output logic [ADDR_W-1:0]      old_status_addr_out,
  output logic                   store_req_out,
  output logic [ADDR_W-1:0]      store_waddr_out,
  output logic [31:0]            store_wdata_out
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] event_select_and_register_mask;
  logic [31:0] watch_area_start;
  logic [31:0] watch_area_end;
  logic        acc_done;
  logic        sel_hit;
  logic [31:0] wmask;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avs_byteenable_in[i]}};
    end
  end

  // One wait cycle, then completion: waitrequest drops after the first edge.
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !acc_done;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_done <= 1'b0;
    end else begin
      acc_done <= (avs_read_in || avs_write_in) && !acc_done;
    end
  end

  assign sel_hit = avs_write_in && acc_done;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_select_and_register_mask <= PEM_SELECT_RST;
      watch_area_start               <= PEM_START_RST;
      watch_area_end                 <= PEM_END_RST;
    end else if (sel_hit) begin
      case (avs_address_in)
        PEM_ADDR_SELECT: event_select_and_register_mask <=
          (event_select_and_register_mask & ~wmask) | (avs_writedata_in & wmask);
        PEM_ADDR_START: watch_area_start <=
          (watch_area_start & ~wmask) | (avs_writedata_in & wmask);
        PEM_ADDR_END: watch_area_end <=
          (watch_area_end & ~wmask) | (avs_writedata_in & wmask);
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  logic [7:0]        sel_bits;
  logic [15:0]       gr_mask;
  logic [ADDR_W-1:0] area_lo;
  logic [ADDR_W-1:0] area_hi;
  logic              ev_branch;
  logic              ev_fetch;
  logic              ev_store;
  logic              ev_greg;
  logic [7:0]        ev_code;
  logic [15:0]       gr_write_rev;

  function automatic logic in_area(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] lo,
                                   input logic [ADDR_W-1:0] hi);
    if (lo <= hi) begin
      in_area = (a >= lo) && (a <= hi); // [RL20]
    end else begin
      in_area = (a >= lo) || (a <= hi); // [RL20]
    end
  endfunction

  // Big-endian numbering: control bit 0 is word bit 31.
  always_comb begin
    for (int i = 0; i < PEM_EVENT_BITS; i++) begin
      sel_bits[i] = event_select_and_register_mask[PEM_SEL_CTL_MSB - i]; // [RL22]
    end
    for (int g = 0; g < PEM_GR_COUNT; g++) begin
      gr_mask[g]      = event_select_and_register_mask[PEM_SEL_MASK_MSB - g]; // [RL5]
      gr_write_rev[g] = gr_write_in[g];
    end
  end

  assign area_lo = watch_area_start[ADDR_W-1:0]; // [RL6] [RL23]
  assign area_hi = watch_area_end[ADDR_W-1:0];   // [RL7] [RL23]

  // A taken branch of a load status word is ordinary flow.
  assign ev_branch = sel_bits[PEM_EV_BRANCH] && is_branch_in && branch_taken_in
                     && !is_load_status_in; // [RL8] [RL9]
  assign ev_fetch  = sel_bits[PEM_EV_FETCH] &&
                     (in_area(instr_addr_in, area_lo, area_hi) ||
                      (exec_valid_in && in_area(exec_addr_in, area_lo, area_hi))); // [RL11]
  // Store flagged on intent, never on data compare.
  assign ev_store  = sel_bits[PEM_EV_STORE] && store_valid_in && !store_cpu_own_in
                     && in_area(store_addr_in, area_lo, area_hi); // [RL13] [RL14]
  // Any masked register among those written, value ignored.
  assign ev_greg   = sel_bits[PEM_EV_GREG] && |(gr_write_rev & gr_mask); // [RL16] [RL17] [RL18]

  always_comb begin
    ev_code = 8'h00; // [RL3]
    ev_code[7 - PEM_EV_BRANCH] = ev_branch;
    ev_code[7 - PEM_EV_FETCH]  = ev_fetch;
    ev_code[7 - PEM_EV_STORE]  = ev_store;
    ev_code[7 - PEM_EV_GREG]   = ev_greg;
  end

  // ----------------------------------------
  // Posting sequence
  // ----------------------------------------
  typedef enum {PEM_IDLE, PEM_CODE, PEM_ADDR, PEM_INT} pem_state_e;
  pem_state_e state;
  logic [7:0]        held_code;
  logic [ADDR_W-1:0] held_addr;
  logic              take;

  // Masked or non-extended events are dropped, not kept pending.
  assign take = instr_done_in && extended_control_mode_in && event_mask_in
                && (ev_code != 8'h00) && (state == PEM_IDLE); // [RL21] [RL22]

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= PEM_IDLE;
    end else begin
      case (state)
        PEM_IDLE: if (take) state <= PEM_CODE;
        PEM_CODE: if (post_ack_in) state <= PEM_ADDR;
        PEM_ADDR: if (post_ack_in) state <= PEM_INT;
        PEM_INT:  if (post_ack_in) state <= PEM_IDLE;
        default:  state <= PEM_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      held_code           <= 8'h00;
      held_addr           <= '0;
      old_status_addr_out <= '0;
    end else if (take) begin
      held_code <= ev_code;
      held_addr <= exec_valid_in ? exec_addr_in : instr_addr_in; // [RL4] [RL12] [RL15] [RL19]
      // Branch target wins over next address when the branch fired.
      old_status_addr_out <= ev_branch ? branch_target_in : next_addr_in; // [RL10] [RL12]
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      store_req_out   <= 1'b0;
      store_waddr_out <= '0;
      store_wdata_out <= 32'h0000_0000;
      int_req_out     <= 1'b0;
      int_code_out    <= 8'h00;
    end else begin
      // Request stands until acknowledged; the partner may answer late
      store_req_out <= (state == PEM_IDLE && take) ||
                       (state == PEM_CODE) ||
                       (state == PEM_ADDR && !post_ack_in);
      int_req_out   <= (state == PEM_ADDR && post_ack_in) ||
                       (state == PEM_INT && !post_ack_in);
      int_code_out  <= PEM_INT_CODE; // [RL1]
      if (take) begin
        store_waddr_out <= PEM_CODE_WORD_ADDR;
        store_wdata_out <= {16'h0000, ev_code, 8'h00}; // [RL2] [RL23]
      end else if (state == PEM_CODE && post_ack_in) begin
        store_waddr_out <= PEM_ADDR_WORD_ADDR;
        store_wdata_out <= {{(32-ADDR_W){1'b0}}, held_addr}; // [RL4]
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !acc_done) begin
      case (avs_address_in)
        PEM_ADDR_SELECT: avs_readdata_out <= event_select_and_register_mask;
        PEM_ADDR_START:  avs_readdata_out <= watch_area_start;
        PEM_ADDR_END:    avs_readdata_out <= watch_area_end;
        PEM_ADDR_STATUS: avs_readdata_out <= {22'h000000, state == PEM_IDLE,
                                              int_req_out, held_code};
        default:         avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ===== shared/pem_pkg.sv
// Constants for the program event monitor
// What this block does
// RL1: A recorded event interruption reports interruption code 80.
// RL2: Event code goes to bits 16-23 of storage word 94, one bit per event.
// RL3: Code bits: 0 branch, 1 fetch, 2 store, 3 register; bits 4-7 zero.
// RL4: Event address goes to bits 8-31 of word 98; execute address if executed.
// RL5: Select register bits 16-31 mask general registers 0 to 15 ascending.
// RL6: Area-start register bits 8-31 hold the first watched address.
// RL7: Area-end register bits 8-31 hold the last watched address.
// RL8: With control bit 0, a taken branch is a successful-branch event.
// RL9: The branch ending a load status word instruction is never an event.
// RL10: Branch event saves target as old status word address; event address is branch.
// RL11: Fetch check tests first byte of instruction and of execute target.
// RL12: Fetch event records fetched instruction address; old word gets next address.
// RL13: With control bit 2, stores into the area count; processor-own stores excluded.
// RL14: A store counts as alteration even if the value is unchanged.
// RL15: Store event address is referencing or execute instruction; next address saved.
// RL16: With control bit 3, a write to a masked general register counts.
// RL17: A register counts as altered even when its value stays the same.
// RL18: Multi-register writes report if any written register is masked.
// RL19: Register event address is referencing or execute instruction; next address saved.
// RL20: Area spans start to end, or wraps through top of storage when end below start.
// RL21: Interruption only with event mask bit set; masked events are discarded.
// RL22: Select bits 0-7 choose events; recording works only in extended mode.
// RL23: Address compares ignore bits 0-7; event code word bits 24-31 are zero.
package pem_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] PEM_ADDR_SELECT  = 4'h0;
  localparam logic [3:0] PEM_ADDR_START   = 4'h4;
  localparam logic [3:0] PEM_ADDR_END     = 4'h8;
  localparam logic [3:0] PEM_ADDR_STATUS  = 4'hC;
  localparam logic [31:0] PEM_SELECT_RST  = 32'h0000_0000;
  localparam logic [31:0] PEM_START_RST   = 32'h0000_0000;
  localparam logic [31:0] PEM_END_RST     = 32'h0000_0000;
  // ----------------------------------------
  // Fields, big-endian bit numbering mapped to little-endian indices
  // ----------------------------------------
  localparam int PEM_EVENT_BITS   = 8;
  localparam int PEM_GR_COUNT     = 16;
  localparam int PEM_ADDR_W       = 24;
  localparam int PEM_SEL_CTL_MSB  = 31;
  localparam int PEM_SEL_MASK_MSB = 15;
  localparam int PEM_EV_BRANCH    = 0;
  localparam int PEM_EV_FETCH     = 1;
  localparam int PEM_EV_STORE     = 2;
  localparam int PEM_EV_GREG      = 3;
  localparam logic [7:0]  PEM_INT_CODE     = 8'h80;
  localparam logic [23:0] PEM_CODE_WORD_ADDR = 24'h000094;
  localparam logic [23:0] PEM_ADDR_WORD_ADDR = 24'h000098;
endpackage
